// File: rtl/dac_channel_regs.sv
/*
 * Double-buffered register pair of both channels: input register and
 * DAC register each, with a registered readback port.
 * Assumes strobes come from the command logic on the same clock.
 */
module dac_channel_regs #(
    parameter int WIDTH = 10
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [1:0] in_we,      // Write input register per channel
    input wire logic [1:0] dac_we,     // Write DAC register with wr_data
    input wire logic [1:0] copy_en,    // Copy input to DAC register
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_sel_b,         // Readback channel select
    output logic [WIDTH-1:0] rd_data,  // Registered readback
    output logic [2*WIDTH-1:0] dac_codes
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] inp;
        logic [1:0][WIDTH-1:0] dac;
        logic [WIDTH-1:0] rd;
    } regs_s;

    regs_s q, d;

    ////////////////////////////////////////////////////////////////////////
    // Next state: writes win over copies for the same channel
    always_comb
    begin
        d = q;
        for (int i = 0; i < 2; i++)
        begin
            if (in_we[i])
                d.inp[i] = wr_data;  // see R16
            if (dac_we[i])
                d.dac[i] = wr_data;  // see R14
            else if (copy_en[i])
                d.dac[i] = q.inp[i];  // see R16
        end
        d.rd = rd_sel_b ? q.dac[1] : q.dac[0];
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign rd_data = q.rd;
    assign dac_codes = {q.dac[1], q.dac[0]};

    // Copy lands one cycle later
    copy_lands_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        copy_en[0] && !dac_we[0] |=> q.dac[0] == $past(q.inp[0]))
        else $error("copy to channel A DAC register missing");  // see R16

endmodule : dac_channel_regs

// File: rtl/dac_serial_ctrl.sv
/*
 * Serial command logic of a dual 10-bit DAC: frame shift register, command
 * decode, chain mode, readback, power modes and load strobe handling.
 * Assumes serial pins are asynchronous to ref_clk; serial clock is at least
 * four times slower than ref_clk so its edges can be found by sampling.
 */
module dac_serial_ctrl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic frame_n,          // Frame select, active low
    input wire logic sclk,             // Serial clock pin
    input wire logic serial_in,
    input wire logic load_strobe_n,
    output logic serial_out,
    output logic serial_out_oe_n,      // Low while driving serial_out
    output logic [19:0] dac_codes,     // {channel B, channel A}
    output logic [1:0] chan_a_power_mode,
    output logic [1:0] chan_b_power_mode,
    output logic chain_mode_bit,
    output logic [1:0] chan_ready      // Output valid per channel {B, A}
);

    localparam int FB = dac_serial_pkg::FRAME_BITS;
    localparam int CW = dac_serial_pkg::CODE_BITS;
    localparam int WC = dac_serial_pkg::WAKE_CYCLES;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,   // Frame select high
        ST_SHIFT = 2'h1,  // Frame select low, taking bits
        ST_EXEC = 2'h3    // One cycle of command execution
    } frame_e;

    typedef struct packed {
        logic [2:0] fs_sync;      // Frame select synchroniser + history
        logic [2:0] ck_sync;      // Serial clock synchroniser + history
        logic [1:0] di_sync;      // Serial data synchroniser
        logic [2:0] ld_sync;      // Load strobe synchroniser + history
        frame_e st;
        logic [FB-1:0] shreg;     // Frame shift register
        logic [FB-1:0] word;      // Word latched at frame end
        logic chain;              // Chain mode enable
        logic rd_armed;           // Readback pending for next frame
        logic rd_active;          // Readback frame in progress
        logic rd_sel_b;           // Readback channel
        logic [FB-1:0] rd_shift;  // Readback shift-out image
        logic so;                 // Serial out level
        logic so_oe_n;
        logic [1:0] pa;           // Channel A power mode
        logic [1:0] pb;           // Channel B power mode
        logic [1:0][12:0] wake;   // Recovery countdown per channel
        logic [1:0] ready;
    } state_s;

    state_s q, d;

    // Strobes into the register pair
    logic [1:0] in_we, dac_we, copy_en;
    logic [CW-1:0] rd_data;
    logic [2*CW-1:0] codes;

    // Address field decode shared by several commands
    function automatic logic [1:0] chan_sel(input logic [FB-1:0] w);
        chan_sel = {w[dac_serial_pkg::ADDR_B_BIT],
                    w[dac_serial_pkg::ADDR_A_BIT]};
    endfunction : chan_sel

    ////////////////////////////////////////////////////////////////////////
    // Edge flags from the second and third synchroniser stages
    logic sck_fall, sck_rise, fs_rise, fs_fall, ld_fall;
    logic frame_low;
    always_comb
    begin
        sck_fall = q.ck_sync[2] && !q.ck_sync[1];
        sck_rise = !q.ck_sync[2] && q.ck_sync[1];
        fs_rise = !q.fs_sync[2] && q.fs_sync[1];
        fs_fall = q.fs_sync[2] && !q.fs_sync[1];
        ld_fall = q.ld_sync[2] && !q.ld_sync[1];
        frame_low = !q.fs_sync[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic [3:0] cmd;
    logic [1:0] sel;
    always_comb
    begin
        d = q;
        in_we = 2'h0;
        dac_we = 2'h0;
        copy_en = 2'h0;
        cmd = q.word[dac_serial_pkg::CMD_MSB:dac_serial_pkg::CMD_LSB];
        sel = chan_sel(q.word);  // see R19

        // Pin synchronisers: first stage read only by the second
        d.fs_sync = {q.fs_sync[1:0], frame_n};
        d.ck_sync = {q.ck_sync[1:0], sclk};
        d.di_sync = {q.di_sync[0], serial_in};
        d.ld_sync = {q.ld_sync[1:0], load_strobe_n};

        // Deferred update on load strobe falling edge while frame select is high, both channels
        if (ld_fall && !frame_low)
            copy_en = 2'h3;  // see R18

        case (q.st)
            ST_IDLE:
            begin
                if (fs_fall)
                begin
                    d.st = ST_SHIFT;
                    if (q.rd_armed)
                    begin
                        // Readback image: 4 filler bits then 16-bit field
                        d.rd_active = 1'b1;  // see R9
                        d.rd_armed = 1'b0;
                        d.rd_shift = {4'h0, rd_data, 6'h00, 4'h0};  // see R11
                        d.so = 1'b0;
                        d.so_oe_n = 1'b0;
                    end
                    else if (q.chain)
                    begin
                        d.so_oe_n = 1'b0;  // see R2
                    end
                end
            end
            ST_SHIFT:
            begin
                if (sck_fall)
                    d.shreg = {q.shreg[FB-2:0], q.di_sync[1]};  // see R20
                if (sck_rise)
                begin
                    // Update output on rising edge, stable for next fall
                    if (q.rd_active)
                    begin
                        d.so = q.rd_shift[FB-1];  // see R3
                        d.rd_shift = {q.rd_shift[FB-2:0], 1'b0};  // see R11
                    end
                    else if (q.chain)
                        d.so = q.shreg[FB-1];  // see R2
                end
                if (fs_rise)
                begin
                    // Any bit count is a valid frame
                    d.word = q.shreg;  // see R5
                    d.st = ST_EXEC;  // see R6
                end
            end
            ST_EXEC:
            begin
                d.st = ST_IDLE;
                d.rd_active = 1'b0;
                d.so_oe_n = 1'b1;  // see R22
                d.so = 1'b0;
                case (cmd)
                    dac_serial_pkg::CMD_WRITE_INPUT:
                    begin
                        in_we = sel;
                        if (!q.ld_sync[1])
                            dac_we = sel;  // see R17
                    end
                    dac_serial_pkg::CMD_UPDATE_DAC:
                        // Keep a deferred copy that lands in this cycle
                        copy_en = copy_en | sel;
                    dac_serial_pkg::CMD_WRITE_UPDATE:
                    begin
                        in_we = sel;
                        dac_we = sel;  // see R21
                    end
                    dac_serial_pkg::CMD_POWER:
                    begin
                        // Address bits are don't care: both fields apply
                        d.pa = q.word[dac_serial_pkg::PWR_A_MSB:
                                      dac_serial_pkg::PWR_A_LSB];  // see R12
                        d.pb = q.word[dac_serial_pkg::PWR_B_MSB:
                                      dac_serial_pkg::PWR_B_LSB];  // see R12
                    end
                    dac_serial_pkg::CMD_CHAIN:
                        d.chain = q.word[dac_serial_pkg::CHAIN_BIT];  // see R1
                    dac_serial_pkg::CMD_READBACK:
                    begin
                        d.rd_armed = 1'b1;  // see R8
                        d.rd_sel_b = (sel == 2'h2);  // see R10
                    end
                    default:
                    begin
                    end
                endcase
            end
            default:
                d.st = ST_IDLE;
        endcase

        // Recovery countdown when leaving power-down
        for (int i = 0; i < 2; i++)
        begin
            if ((i == 0 ? d.pa : d.pb) != dac_serial_pkg::PWR_NORMAL)
            begin
                d.ready[i] = 1'b0;  // see R13
                d.wake[i] = 13'(WC);
            end
            else if (q.wake[i] != 13'h0000)
            begin
                d.wake[i] = q.wake[i] - 13'h0001;  // see R15
                d.ready[i] = (q.wake[i] == 13'h0001);
            end
            else
                d.ready[i] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.fs_sync <= 3'h7;
            q.ck_sync <= 3'h7;
            q.ld_sync <= 3'h7;
            q.st <= ST_IDLE;
            q.chain <= dac_serial_pkg::CHAIN_RESET;
            q.so_oe_n <= 1'b1;
            q.pa <= dac_serial_pkg::PWR_RESET;
            q.pb <= dac_serial_pkg::PWR_RESET;
            q.ready <= 2'h3;
        end
        else
            q <= d;
    end

    // Channel register pair with registered readback
    dac_channel_regs #(
        .WIDTH(CW)
    ) u_regs (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_we(in_we),
        .dac_we(dac_we),
        .copy_en(copy_en),
        .wr_data(q.word[dac_serial_pkg::DATA_MSB:dac_serial_pkg::DATA_LSB]),
        .rd_sel_b(q.rd_sel_b),
        .rd_data(rd_data),
        .dac_codes(codes)
    );

    // Outputs straight from flip-flops
    logic [2*CW-1:0] codes_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            codes_q <= '0;
        else
            codes_q <= codes;
    end

    assign dac_codes = codes_q;
    assign serial_out = q.so;
    assign serial_out_oe_n = q.so_oe_n;
    assign chan_a_power_mode = q.pa;
    assign chan_b_power_mode = q.pb;
    assign chain_mode_bit = q.chain;
    assign chan_ready = q.ready;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence exec_chain_s;
        q.st == ST_EXEC && cmd == dac_serial_pkg::CMD_CHAIN;
    endsequence

    chain_bit_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        exec_chain_s |=> q.chain == $past(q.word[0]))
        else $error("chain mode bit not taken");  // see R1

    frame_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_SHIFT && fs_rise
        |=> q.st == ST_EXEC && q.word == $past(q.shreg))
        else $error("frame word not latched at frame end");  // see R6

    no_shift_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_IDLE |=> q.shreg == $past(q.shreg))
        else $error("shift register moved outside a frame");  // see R6

    out_on_rise_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_SHIFT && !sck_rise |=> $stable(q.so))
        else $error("serial out changed off a rising edge");  // see R3

    drive_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_EXEC |=> q.so_oe_n)
        else $error("serial out still driven after frame");  // see R22

    readback_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_IDLE && fs_fall && q.rd_armed
        |=> !q.so_oe_n ##1 q.rd_active)
        else $error("readback frame not driving serial out");  // see R9

    standalone_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !q.chain && !q.rd_active && q.st == ST_SHIFT |-> q.so_oe_n)
        else $error("serial out driven in standalone mode");  // see R22

    // Own count of cycles since channel A left power-down; a counter
    // because the recovery is far too long for a plain delay
    logic [12:0] wake_cnt_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            wake_cnt_q <= 13'(WC - 1);
        else if (q.pa != dac_serial_pkg::PWR_NORMAL)
            wake_cnt_q <= 13'h0000;
        else if (!q.ready[0])
            wake_cnt_q <= wake_cnt_q + 13'h0001;
    end

    wake_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.pa == dac_serial_pkg::PWR_NORMAL
        |-> q.ready[0] == (wake_cnt_q >= 13'(WC - 1)))
        else $error("channel A recovery time wrong");  // see R15

    load_direct_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_EXEC && cmd == dac_serial_pkg::CMD_WRITE_INPUT
        && sel[0] && !q.ld_sync[1] |-> dac_we[0])
        else $error("direct update with strobe low missing");  // see R17

    readback_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == ST_EXEC && cmd == dac_serial_pkg::CMD_READBACK && sel != 2'h2
        |=> !q.rd_sel_b && q.rd_armed)
        else $error("readback default channel not A");  // see R10

endmodule : dac_serial_ctrl

// File: shared/dac_serial_pkg.sv
/*
 * Constants for the dual-channel serial DAC command logic: frame layout,
 * command codes, power modes, timing counts and reset values.
 * Assumes a 250 MHz core clock that samples the serial pins.
 */
// What this block does
// R1: Command 1000 bit 0 sets chain mode
// R2: Chain mode shifts overflow bits to serial_out
// R3: Serial output changes on rising serial clock
// R4: Host sends 24 clocks per chained device
// R5: Odd-length frames still execute on frame end
// R6: Frame end latches word, blocks further bits
// R7: Free-running clock only with exact frame hold
// R8: Command 1001 selects channel register readback
// R9: Readback drives serial_out even when standalone
// R10: Zero or several address bits read channel A
// R11: Next frame shifts out readback register
// R12: Command 0100 sets per-channel power modes
// R13: Power mode decode: normal, 1k, 100k, hi-Z
// R14: DAC register kept and writable while powered down
// R15: Power-up recovery takes about 4.5 us
// R16: Input register then DAC register per channel
// R17: Load strobe low: 0001 updates DAC too
// R18: Load strobe falling edge copies both channels; edges while frame select is low are ignored
// R19: 24-bit frame: command, address, data, MSB first
// R20: Sample serial_in on falling serial clock
// R21: Command 0011 writes and updates DAC directly
// R22: Serial output undriven when standalone and idle
package dac_serial_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_B_BIT = 19;
    localparam int ADDR_A_BIT = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 6;
    localparam int CODE_BITS = 10;
    localparam int CHAIN_BIT = 0;
    localparam int PWR_B_MSB = 7;
    localparam int PWR_B_LSB = 6;
    localparam int PWR_A_MSB = 1;
    localparam int PWR_A_LSB = 0;
    localparam int READ_FIELD_BITS = 16;

    ////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CHAIN = 4'h8;
    localparam logic [3:0] CMD_READBACK = 4'h9;

    // Power mode encodings
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_1K = 2'h1;
    localparam logic [1:0] PWR_100K = 2'h2;
    localparam logic [1:0] PWR_HIZ = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int WAKE_NS = 4500;  // 4.5 us power-up recovery
    localparam int WAKE_CYCLES = (WAKE_NS * CLK_MHZ) / 1000;

    // Reset values
    localparam logic CHAIN_RESET = 1'b0;
    localparam logic [1:0] PWR_RESET = 2'h0;
    localparam logic [9:0] CODE_RESET = 10'h000;

endpackage : dac_serial_pkg

// File: test/dac_serial_ctrl_tb_top.sv
/*
 * Self-checking bench for the DAC serial command block: writes, strobe
 * handling, readback, power modes, recovery and chain mode.
 * Assumes the host model drives all serial pins; bench owns the strobe.
 */
module dac_serial_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic ref_clk = 1'b0; // 250 MHz core clock
    logic rstn; // Synchronous reset, active low
    logic load_strobe_n; // Load strobe pin
    logic frame_n;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    logic [19:0] dac_codes; // {B, A}
    logic [1:0] chan_a_power_mode;
    logic [1:0] chan_b_power_mode;
    logic chain_mode_bit;
    logic [1:0] chan_ready;
    int error_cnt = 0;
    int checks = 0;

    // Half period of 2 ns
    always #2 ref_clk = ~ref_clk;

    dac_serial_ctrl u_dac_serial_ctrl (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .frame_n(frame_n),
        .sclk(sclk),
        .serial_in(serial_in),
        .load_strobe_n(load_strobe_n),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .dac_codes(dac_codes),
        .chan_a_power_mode(chan_a_power_mode),
        .chan_b_power_mode(chan_b_power_mode),
        .chain_mode_bit(chain_mode_bit),
        .chan_ready(chan_ready)
    );

    host_serial_model u_host_serial_model (
        .ref_clk(ref_clk),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .frame_n(frame_n),
        .sclk(sclk),
        .serial_in(serial_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // Four-state compare so an unknown never passes
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // Frame word: command, B, two zeros, A, code, six spare bits
    function automatic logic [23:0] mk(input logic [3:0] cmd, input logic b,
                                       input logic a, input logic [9:0] code);
        return {cmd, b, 2'b00, a, code, 6'h00};
    endfunction : mk

    // Plain 24-clock frame
    task automatic send(input logic [23:0] w);
        u_host_serial_model.xfer({24'h0, w}, 24);
    endtask : send

    // Single exit of the run
    task automatic test_done;
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [1:0] pm;
        int t;
        rstn = 1'b0;
        load_strobe_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Reset state: standalone, normal power, output undriven
        chk(dac_codes, 0);
        chk({chain_mode_bit, chan_b_power_mode, chan_a_power_mode}, 0);
        chk(serial_out_oe_n, 1);
        // Write and update both channels, strobe high
        send(mk(dac_serial_pkg::CMD_WRITE_UPDATE, 1, 1, 10'h2A5));
        chk(dac_codes, {10'h2A5, 10'h2A5});
        chk(u_host_serial_model.oe_seen, 0);
        // Deferred path: input registers move, DAC registers wait
        send(mk(dac_serial_pkg::CMD_WRITE_INPUT, 0, 1, 10'h155));
        send(mk(dac_serial_pkg::CMD_WRITE_INPUT, 1, 0, 10'h3FF));
        chk(dac_codes, {10'h2A5, 10'h2A5});
        @(posedge ref_clk);
        load_strobe_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(dac_codes, {10'h3FF, 10'h155});
        // Strobe held low: input write reaches the DAC register at once
        send(mk(dac_serial_pkg::CMD_WRITE_INPUT, 1, 0, 10'h001));
        chk(dac_codes, {10'h001, 10'h155});
        load_strobe_n <= 1'b1;
        // Strobe high: input write waits, update command moves it
        send(mk(dac_serial_pkg::CMD_WRITE_INPUT, 0, 1, 10'h0C3));
        chk(dac_codes, {10'h001, 10'h155});
        send(mk(dac_serial_pkg::CMD_UPDATE_DAC, 0, 1, 10'h000));
        chk(dac_codes, {10'h001, 10'h0C3});
        // Readback for every address pattern; only B alone reads B
        for (int k = 0; k < 4; k++)
        begin
            send(mk(dac_serial_pkg::CMD_READBACK, k[1], k[0], 10'h0AA));
            send(24'h0);
            chk(u_host_serial_model.rx_word[19:4],
                {(k == 2) ? 10'h001 : 10'h0C3, 6'h00});
            chk(u_host_serial_model.oe_seen, 1);
            chk(serial_out_oe_n, 1);
        end
        // Overlong frame of 28 clocks still executes its last 24 bits
        u_host_serial_model.xfer({20'h0, 4'hA,
            mk(dac_serial_pkg::CMD_WRITE_UPDATE, 0, 1, 10'h0F0)}, 28);
        chk(dac_codes, {10'h001, 10'h0F0});
        // Every power code on both channels, bits 5:2 as ones
        for (int m = 0; m < 4; m++)
        begin
            pm = m[1:0];
            send({dac_serial_pkg::CMD_POWER, 12'h000, pm, 4'hF, ~pm});
            chk({chan_b_power_mode, chan_a_power_mode}, {pm, ~pm});
        end
        // B powered down, A only just woken and still recovering
        chk(chan_ready, 2'b00);
        // Powered-down channel keeps and accepts its register
        chk(dac_codes[19:10], 10'h001);
        send(mk(dac_serial_pkg::CMD_WRITE_UPDATE, 1, 0, 10'h2C3));
        chk(dac_codes[19:10], 10'h2C3);
        // Wake B and time its recovery, bounded wait
        send({dac_serial_pkg::CMD_POWER, 12'h000, 8'h3C});
        t = 0;
        while (chan_ready[1] !== 1'b1 && t < 2000)
        begin
            @(posedge ref_clk);
            t++;
        end
        chk(t >= dac_serial_pkg::WAKE_CYCLES - 40, 1);
        chk(t <= dac_serial_pkg::WAKE_CYCLES, 1);
        chk(chan_ready, 2'b11);
        // Chain mode: two words, the first ripples out after 24 clocks
        send(mk(dac_serial_pkg::CMD_CHAIN, 0, 0, 10'h000) | 24'h000001);
        chk(chain_mode_bit, 1);
        u_host_serial_model.xfer(
            {mk(dac_serial_pkg::CMD_WRITE_UPDATE, 0, 1, 10'h111),
             mk(dac_serial_pkg::CMD_WRITE_UPDATE, 1, 0, 10'h222)}, 48);
        chk(u_host_serial_model.rx_word[23:0],
            mk(dac_serial_pkg::CMD_WRITE_UPDATE, 0, 1, 10'h111));
        chk(dac_codes, {10'h222, 10'h0F0});
        // Back to standalone: output released again
        send(mk(dac_serial_pkg::CMD_CHAIN, 0, 0, 10'h000));
        chk(chain_mode_bit, 0);
        send(24'h0);
        chk(u_host_serial_model.oe_seen, 0);
        test_done();
    end

    // Watchdog well beyond the expected run of some 15k cycles
    initial
    begin
        #120000;
        error_cnt++;
        test_done();
    end

endmodule : dac_serial_ctrl_tb_top

// File: test/host_serial_model.sv
/*
 * Behavioural host serial controller that sends framed words to the DAC
 * command block and records what comes back on serial_out.
 * Assumes ref_clk paces every pin change; half serial period is ten clocks.
 */
module host_serial_model (
    input wire logic ref_clk,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    output logic frame_n,
    output logic sclk,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic [47:0] rx_word; // Bits caught on falling serial clock
    logic oe_seen; // Output driven at some capture of the frame

    // Idle pins: frame high, serial clock parked low
    initial
    begin
        frame_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        rx_word = 48'h0;
        oe_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One gated burst of nbits clocks, MSB first; clock stops between frames
    task automatic xfer(input logic [47:0] word, input int nbits);
        rx_word = 48'h0;
        oe_seen = 1'b0;
        @(posedge ref_clk);
        frame_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            // Data moves with the rise, far from the sampling fall
            serial_in <= word[i];
            sclk <= 1'b1;
            repeat (10) @(posedge ref_clk);
            sclk <= 1'b0;
            // Undriven line reads as the inverse, never a stale copy
            rx_word = {rx_word[46:0],
                       serial_out ^ serial_out_oe_n};
            oe_seen = oe_seen | ~serial_out_oe_n;
            repeat (10) @(posedge ref_clk);
        end
        // Exact burst, then frame closes; no free-running clock
        frame_n <= 1'b1;
        // Released data line shows the inverse, not a stale copy
        serial_in <= ~word[0];
        repeat (16) @(posedge ref_clk);
    endtask : xfer

endmodule : host_serial_model
